// File: common/ulm_defs.vh
/*
  Constants shared by the serial line-mode logic: register offsets,
  field positions, mode codes, reset values and tick counts.
  Assumes 8-bit byte addresses on a 32-bit register port and a 16x bit tick.
*/
// Overview of operation
// - Smart-card T=1: one stop bit, parity checked
// - Mode 0x8 enables infrared modulator and demodulator
// - Infrared zero sends a 3/16 bit pulse
// - Falling edge starts 8-bit filter down counter
// - Rising edge during filtering reloads, rejects pulse
// - Counter at zero drives receiver low one bit
// - Mode 0x1: RTS is inverse of transmitter empty
// - RTS stays high through timeguard after character
// - Mode 0x3: terminal drives DTR/RTS, watches inputs
// - Disable command drives pin high, enable low
// - Modem input level change sets its flag
// - Reading channel status clears change flags
// - CTS high stops transmitter after current character
// - Normal: receive pin to receiver, transmitter to pin
// - Echo: receive pin copied to transmit pin
// - Local loopback: transmitter to receiver, pin high
// - Remote loopback: receive pin to transmit pin
`ifndef ULM_DEFS_VH
`define ULM_DEFS_VH

`define ULM_OFF_CMD 8'h00
`define ULM_OFF_MODE 8'h04
`define ULM_OFF_CSR 8'h14
`define ULM_OFF_TG 8'h28
`define ULM_OFF_RATIO 8'h40
`define ULM_OFF_IRF 8'h4c

`define ULM_MODE_NORMAL 4'h0
`define ULM_MODE_RS485 4'h1
`define ULM_MODE_MODEM 4'h3
`define ULM_MODE_CARD_T1 4'h6
`define ULM_MODE_IR 4'h8

`define ULM_CHM_NORMAL 2'h0
`define ULM_CHM_ECHO 2'h1
`define ULM_CHM_LOCAL 2'h2
`define ULM_CHM_REMOTE 2'h3

`define ULM_PAR_EVEN 3'h0
`define ULM_PAR_ODD 3'h1
`define ULM_PAR_SPACE 3'h2
`define ULM_PAR_MARK 3'h3

// Mode register fields
`define ULM_MR_MODE 3:0
`define ULM_MR_PAR 11:9
`define ULM_MR_CHM 15:14
// Command register bits
`define ULM_CR_RSTSTA 8
`define ULM_CR_DTR_ASSERT 16
`define ULM_CR_DTR_DEASSERT 17
`define ULM_CR_RTS_ASSERT 18
`define ULM_CR_RTS_DEASSERT 19
// Channel status bits
`define ULM_CSR_PAR_ERR 7
`define ULM_CSR_TX_EMPTY 9
`define ULM_CSR_CHG 19:16
`define ULM_CSR_LVL 23:20

`define ULM_RATIO_W 11
`define ULM_RATIO_RST 11'h174
`define ULM_IR_PULSE_TICKS 5'h03
`define ULM_TICKS_LAST 4'hf

`endif

// File: rtl/ulm_chg_det.v
/*
  Level-change detector for one modem input with a sticky flag.
  Assumes the input is synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module ulm_chg_det (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Control
  input wire en,
  input wire clr,
  // Line
  input wire level,
  output reg flag_q,
  output reg lvl_q
);
  wire change;

  assign change = en & (level != lvl_q);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b1;
      flag_q <= 1'b0;
    end else if (ce) begin
      lvl_q <= level;
      // Set beats a clear in the same cycle
      if (change) begin
        flag_q <= 1'b1;
      end else if (clr) begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/ulm_line_modes.v
/*
  Line-mode logic of a serial transceiver: smart-card parity, infrared
  modulator and filtering demodulator, RS485 driver control, modem lines
  and the four channel test modes, with a small register port.
  Assumes the core transmitter and receiver sit beside it, a 16x bit tick
  and pins synchronous to clk_sys.
*/
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ulm_defs.vh"
module ulm_line_modes #(
  parameter FILT_W = 8,
  parameter TG_W = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Core transmitter
  input wire tick16,
  input wire tx_bit,
  input wire tx_bit_start,
  input wire tx_busy,
  input wire tx_idle,
  input wire [7:0] tx_char,
  output reg tx_par_q,
  output reg tx_allow_q,
  // Core receiver
  input wire rx_done,
  input wire [7:0] rx_char,
  input wire rx_par,
  output reg rx_bit_q,
  output reg rx_allow_q,
  // Line pins
  input wire rxd,
  input wire cts,
  input wire dsr,
  input wire dcd,
  input wire ri,
  output reg txd_q,
  output reg rts_q,
  output reg dtr_q
);
  localparam [2:0] DM_IDLE = 3'b001;
  localparam [2:0] DM_FILT = 3'b010;
  localparam [2:0] DM_LOW = 3'b100;

  // Software-visible state
  reg [3:0] mode_q;
  reg [2:0] par_q;
  reg [1:0] chm_q;
  reg [FILT_W-1:0] irf_q;
  reg [TG_W-1:0] tg_q;
  reg [`ULM_RATIO_W-1:0] ratio_q;
  reg par_err_q;
  reg rts_cmd_q;
  reg dtr_cmd_q;
  // Line state
  reg [4:0] mod_cnt_q;
  reg rxd_prev_q;
  reg [2:0] dm_st_q;
  reg [FILT_W-1:0] filt_cnt_q;
  reg [3:0] low_tick_q;
  reg [TG_W-1:0] tg_cnt_q;
  reg [3:0] tg_tick_q;
  reg empty_q;

  wire is_ir;
  wire is_modem;
  wire is_485;
  wire is_t1;
  wire wr_cmd;
  wire rd_csr;
  wire [3:0] chg_flags;
  wire [3:0] chg_lvls;
  wire fall;
  wire rise;
  wire ir_tx;
  wire ir_rx;
  wire tx_src;
  wire rx_src;
  wire par_on;
  wire rx_exp;

  assign is_ir = (mode_q == `ULM_MODE_IR);
  assign is_modem = (mode_q == `ULM_MODE_MODEM);
  assign is_485 = (mode_q == `ULM_MODE_RS485);
  assign is_t1 = (mode_q == `ULM_MODE_CARD_T1);
  assign wr_cmd = reg_wr & (reg_addr == `ULM_OFF_CMD);
  assign rd_csr = reg_rd & (reg_addr == `ULM_OFF_CSR);

  // Expected parity bit for a character
  function par_bit;
    input [7:0] data;
    input [2:0] ptype;
    input t1;
    begin
      if (t1) begin
        par_bit = ^data;
      end else begin
        case (ptype)
          `ULM_PAR_EVEN: par_bit = ^data;
          `ULM_PAR_ODD: par_bit = ~^data;
          `ULM_PAR_SPACE: par_bit = 1'b0;
          `ULM_PAR_MARK: par_bit = 1'b1;
          default: par_bit = 1'b0;
        endcase
      end
    end
  endfunction

  // Card mode always carries even parity
  assign par_on = is_t1 | ~par_q[2];
  assign rx_exp = par_bit(rx_char, par_q, is_t1);

  // Register writes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `ULM_MODE_NORMAL;
      par_q <= `ULM_PAR_EVEN;
      chm_q <= `ULM_CHM_NORMAL;
      irf_q <= {FILT_W{1'b0}};
      tg_q <= {TG_W{1'b0}};
      ratio_q <= `ULM_RATIO_RST;
      rts_cmd_q <= 1'b1;
      dtr_cmd_q <= 1'b1;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `ULM_OFF_MODE: begin
          mode_q <= reg_wdata[`ULM_MR_MODE];
          par_q <= reg_wdata[`ULM_MR_PAR];
          chm_q <= reg_wdata[`ULM_MR_CHM];
        end
        `ULM_OFF_IRF: irf_q <= reg_wdata[FILT_W-1:0];
        `ULM_OFF_TG: tg_q <= reg_wdata[TG_W-1:0];
        `ULM_OFF_RATIO: ratio_q <= reg_wdata[`ULM_RATIO_W-1:0];
        `ULM_OFF_CMD: begin
          // Deassert wins when both command bits are set
          if (reg_wdata[`ULM_CR_RTS_DEASSERT]) begin
            rts_cmd_q <= 1'b1;
          end else if (reg_wdata[`ULM_CR_RTS_ASSERT]) begin
            rts_cmd_q <= 1'b0;
          end
          if (reg_wdata[`ULM_CR_DTR_DEASSERT]) begin
            dtr_cmd_q <= 1'b1;
          end else if (reg_wdata[`ULM_CR_DTR_ASSERT]) begin
            dtr_cmd_q <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Parity generation and parity error flag
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_par_q <= 1'b0;
      par_err_q <= 1'b0;
    end else if (ce) begin
      tx_par_q <= par_bit(tx_char, par_q, is_t1);
      if (rx_done && par_on && (rx_par != rx_exp)) begin
        par_err_q <= 1'b1;
      end else if (wr_cmd && reg_wdata[`ULM_CR_RSTSTA]) begin
        par_err_q <= 1'b0;
      end
    end
  end

  // Modem input change flags
  ulm_chg_det u_chg_ri (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .en(is_modem), .clr(rd_csr),
    .level(ri), .flag_q(chg_flags[0]), .lvl_q(chg_lvls[0])
  );
  ulm_chg_det u_chg_dsr (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .en(is_modem), .clr(rd_csr),
    .level(dsr), .flag_q(chg_flags[1]), .lvl_q(chg_lvls[1])
  );
  ulm_chg_det u_chg_dcd (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .en(is_modem), .clr(rd_csr),
    .level(dcd), .flag_q(chg_flags[2]), .lvl_q(chg_lvls[2])
  );
  ulm_chg_det u_chg_cts (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .en(is_modem), .clr(rd_csr),
    .level(cts), .flag_q(chg_flags[3]), .lvl_q(chg_lvls[3])
  );

  // Register reads, data valid in the following cycle only
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `ULM_OFF_MODE: begin
            reg_rdata[`ULM_MR_MODE] <= mode_q;
            reg_rdata[`ULM_MR_PAR] <= par_q;
            reg_rdata[`ULM_MR_CHM] <= chm_q;
          end
          `ULM_OFF_CSR: begin
            reg_rdata[`ULM_CSR_PAR_ERR] <= par_err_q;
            reg_rdata[`ULM_CSR_TX_EMPTY] <= empty_q;
            reg_rdata[`ULM_CSR_CHG] <= chg_flags;
            reg_rdata[`ULM_CSR_LVL] <= chg_lvls;
          end
          `ULM_OFF_IRF: reg_rdata[FILT_W-1:0] <= irf_q;
          `ULM_OFF_TG: reg_rdata[TG_W-1:0] <= tg_q;
          `ULM_OFF_RATIO: reg_rdata[`ULM_RATIO_W-1:0] <= ratio_q;
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Infrared modulator: low pulse of 3 ticks at the start of a zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt_q <= 5'h00;
    end else if (ce) begin
      if (tx_bit_start) begin
        mod_cnt_q <= tx_bit ? 5'h00 : `ULM_IR_PULSE_TICKS;
      end else if (tick16 && (mod_cnt_q != 5'h00)) begin
        mod_cnt_q <= mod_cnt_q - 5'h01;
      end
    end
  end
  assign ir_tx = (mod_cnt_q == 5'h00);

  // Infrared demodulator with pulse-width filter
  assign fall = rxd_prev_q & ~rxd;
  assign rise = ~rxd_prev_q & rxd;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxd_prev_q <= 1'b1;
      dm_st_q <= DM_IDLE;
      filt_cnt_q <= {FILT_W{1'b0}};
      low_tick_q <= 4'h0;
    end else if (ce) begin
      rxd_prev_q <= rxd;
      case (dm_st_q)
        DM_IDLE: begin
          filt_cnt_q <= irf_q;
          if (fall && is_ir) begin
            dm_st_q <= DM_FILT;
          end
        end
        DM_FILT: begin
          if (rise) begin
            filt_cnt_q <= irf_q;
            dm_st_q <= DM_IDLE;
          end else if (filt_cnt_q == {FILT_W{1'b0}}) begin
            low_tick_q <= 4'h0;
            dm_st_q <= DM_LOW;
          end else begin
            filt_cnt_q <= filt_cnt_q - {{(FILT_W-1){1'b0}}, 1'b1};
          end
        end
        DM_LOW: begin
          // Sixteen ticks make one bit time
          if (tick16) begin
            low_tick_q <= low_tick_q + 4'h1;
            if (low_tick_q == `ULM_TICKS_LAST) begin
              dm_st_q <= DM_IDLE;
            end
          end
        end
        default: dm_st_q <= DM_IDLE;
      endcase
    end
  end
  assign ir_rx = (dm_st_q != DM_LOW);

  // Transmitter empty held off through the timeguard
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tg_cnt_q <= {TG_W{1'b0}};
      tg_tick_q <= 4'h0;
      empty_q <= 1'b1;
    end else if (ce) begin
      if (!tx_idle) begin
        tg_cnt_q <= tg_q;
        tg_tick_q <= 4'h0;
      end else if (tick16 && (tg_cnt_q != {TG_W{1'b0}})) begin
        tg_tick_q <= tg_tick_q + 4'h1;
        if (tg_tick_q == `ULM_TICKS_LAST) begin
          tg_cnt_q <= tg_cnt_q - {{(TG_W-1){1'b0}}, 1'b1};
        end
      end
      empty_q <= tx_idle && (tg_cnt_q == {TG_W{1'b0}});
    end
  end

  // Pin control and channel routing
  assign tx_src = is_ir ? ir_tx : tx_bit;
  assign rx_src = is_ir ? ir_rx : rxd;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txd_q <= 1'b1;
      rx_bit_q <= 1'b1;
      rts_q <= 1'b1;
      dtr_q <= 1'b1;
      tx_allow_q <= 1'b1;
      rx_allow_q <= 1'b1;
    end else if (ce) begin
      rts_q <= is_485 ? ~empty_q : rts_cmd_q;
      dtr_q <= dtr_cmd_q;
      // Character in flight finishes before the stop takes hold
      tx_allow_q <= (chm_q != `ULM_CHM_REMOTE) &&
                    (!(is_modem && cts) || (tx_allow_q && tx_busy));
      rx_allow_q <= (chm_q != `ULM_CHM_REMOTE);
      case (chm_q)
        `ULM_CHM_NORMAL: begin
          txd_q <= tx_src;
          rx_bit_q <= rx_src;
        end
        `ULM_CHM_ECHO: begin
          txd_q <= rxd;
          rx_bit_q <= rx_src;
        end
        `ULM_CHM_LOCAL: begin
          txd_q <= 1'b1;
          rx_bit_q <= tx_bit;
        end
        `ULM_CHM_REMOTE: begin
          txd_q <= rxd;
          rx_bit_q <= 1'b1;
        end
        default: begin
          txd_q <= 1'b1;
          rx_bit_q <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/ulm_line_modes_checker.sv
/* Checker for ulm_line_modes: command pins, CTS gating, RS485 RTS, routing.
   Assumes ce tied high and only the top module's ports in view. */
`timescale 1ns/1ps
`default_nettype none
`include "ulm_defs.vh"
module ulm_line_modes_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Core side
  input wire logic tx_bit,
  input wire logic tx_busy,
  input wire logic tx_idle,
  input wire logic tx_allow_q,
  input wire logic rx_allow_q,
  input wire logic rx_bit_q,
  // Pins
  input wire logic rxd,
  input wire logic cts,
  input wire logic txd_q,
  input wire logic rts_q,
  input wire logic dtr_q
);
  logic [3:0] md_q;
  logic [1:0] chm_q;
  logic cw;
  // Mode shadow, since the mode register is not a port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      md_q <= 4'h0;
      chm_q <= 2'h0;
    end else if (reg_wr && reg_addr == `ULM_OFF_MODE) begin
      md_q <= reg_wdata[3:0];
      chm_q <= reg_wdata[15:14];
    end
  end
  assign cw = reg_wr && reg_addr == `ULM_OFF_CMD;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_tx_on;
    (md_q == `ULM_MODE_RS485 && !tx_idle) [*2];
  endsequence
  chk_dtr_low: assert property (cw && reg_wdata[16] && !reg_wdata[17] |-> ##2 !dtr_q)
    else $error("dtr not driven low");
  chk_dtr_high: assert property (cw && reg_wdata[17] |-> ##2 dtr_q)
    else $error("dtr not driven high");
  chk_rts_low: assert property (cw && reg_wdata[18] && !reg_wdata[19] && md_q != `ULM_MODE_RS485 |-> ##2 !rts_q)
    else $error("rts not driven low");
  chk_rs485_rts: assert property (s_tx_on |=> rts_q)
    else $error("rts low while transmitting");
  chk_cts_gate: assert property (md_q == `ULM_MODE_MODEM && cts && !tx_busy |=> !tx_allow_q)
    else $error("transmitter allowed with cts high");
  chk_cts_hold: assert property (md_q == `ULM_MODE_MODEM && chm_q != `ULM_CHM_REMOTE && tx_allow_q && tx_busy
    |=> tx_allow_q)
    else $error("character cut short");
  chk_normal_path: assert property (md_q == 4'h0 && chm_q == `ULM_CHM_NORMAL
    |=> txd_q == $past(tx_bit) && rx_bit_q == $past(rxd))
    else $error("normal routing wrong");
  chk_echo_path: assert property (md_q == 4'h0 && chm_q == `ULM_CHM_ECHO
    |=> txd_q == $past(rxd) && rx_bit_q == $past(rxd))
    else $error("echo routing wrong");
  chk_local_path: assert property (md_q == 4'h0 && chm_q == `ULM_CHM_LOCAL |=> txd_q && rx_bit_q == $past(tx_bit))
    else $error("local loop routing wrong");
  chk_remote_path: assert property (chm_q == `ULM_CHM_REMOTE
    |=> txd_q == $past(rxd) && !tx_allow_q && !rx_allow_q)
    else $error("remote loop routing wrong");
endmodule
bind ulm_line_modes ulm_line_modes_checker u_chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .tx_bit,
  .tx_busy, .tx_idle, .tx_allow_q, .rx_allow_q, .rx_bit_q, .rxd, .cts, .txd_q, .rts_q, .dtr_q);
`default_nettype wire

// File: tb/ulm_line_peer.sv
/* Line peer: modem or infrared transceiver as seen from the pins.
   Assumes its tasks are called right after a rising clk_sys edge. */
`timescale 1ns/1ps
`default_nettype none
module ulm_line_peer (
  // Clock
  input wire logic clk_sys,
  // Lines towards the block, idle high
  output var logic rxd,
  output var logic cts,
  output var logic dsr,
  output var logic dcd,
  output var logic ri
);
  initial begin
    rxd = 1'h1;
    {cts, dcd, dsr, ri} = 4'hf;
  end
  task automatic set_rx(input logic v);
    rxd <= v;
  endtask
  // Bit 0 ri up to bit 3 cts
  task automatic set_m(input logic [3:0] m);
    {cts, dcd, dsr, ri} <= m;
  endtask
  // Light pulse: receive line low for k cycles
  task automatic pulse(input int k);
    rxd <= 1'h0;
    repeat (k) @(posedge clk_sys);
    rxd <= 1'h1;
  endtask
endmodule
`default_nettype wire

// File: tb/test_usart_line_modes.sv
/* Bench for ulm_line_modes: register tasks, a line peer and directed cases.
   Assumes 100 MHz clk_sys and a 16x tick every 4 cycles. */
`timescale 1ns/1ps
`default_nettype none
`include "ulm_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_usart_line_modes;
  logic clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, tick16 = 1'h0;
  logic tx_bit = 1'h1, tx_bit_start = 1'h0, tx_busy = 1'h0, tx_idle = 1'h1, rx_done = 1'h0, rx_par = 1'h0;
  logic [7:0] reg_addr = 8'h0, tx_char = 8'h0, rx_char = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [1:0] tc = 2'h0;
  logic tx_par_q, tx_allow_q, rx_bit_q, rx_allow_q, rxd, cts, dsr, dcd, ri, txd_q, rts_q, dtr_q;
  int miscompares = 0, check_count = 0, n, i, c1, c2;
  ulm_line_modes u_dut (.clk_sys, .rst_n, .ce(1'h1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tick16, .tx_bit, .tx_bit_start, .tx_busy, .tx_idle, .tx_char, .tx_par_q, .tx_allow_q, .rx_done,
    .rx_char, .rx_par, .rx_bit_q, .rx_allow_q, .rxd, .cts, .dsr, .dcd, .ri, .txd_q, .rts_q, .dtr_q);
  ulm_line_peer u_peer (.clk_sys, .rxd, .cts, .dsr, .dcd, .ri);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tc <= tc + 2'h1;
    tick16 <= (tc == 2'h3);
  end
  task automatic w(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  // Data is taken at the edge that closes its one valid cycle
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(posedge clk_sys);
    `CHK(s, e, reg_rdata & m)
  endtask
  task automatic lows(input int k, input logic sel, output int c);
    c = 0;
    repeat (k) begin
      @(posedge clk_sys);
      c += ((sel ? rx_bit_q : txd_q) === 1'h0);
    end
  endtask
  task wrap_up;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    w(20000);
    miscompares++;
    wrap_up;
  end
  initial begin
    w(6);
    rst_n <= 1'h1;
    rc(`ULM_OFF_MODE, 32'hffffffff, 32'h0, "mode");
    rc(`ULM_OFF_RATIO, 32'h7ff, 32'h174, "ratio");
    rc(`ULM_OFF_TG, 32'hff, 32'h0, "tg");
    rc(`ULM_OFF_CMD, 32'hffffffff, 32'h0, "cmd");
    wr(8'h30, 32'hffffffff);
    rc(8'h30, 32'hffffffff, 32'h0, "unmapped");
    for (i = 0; i < 4; i++) begin
      wr(`ULM_OFF_MODE, 32'(i << 14));
      for (n = 0; n < 2; n++) begin
        tx_bit <= n[0];
        u_peer.set_rx(!n[0]);
        w(3);
        `CHK("txd", (i == 2) ? 1'h1 : (i == 0) ? n[0] : !n[0], txd_q)
        if (i == 3) `CHK("allow", 2'h0, {tx_allow_q, rx_allow_q})
        else `CHK("rxb", (i == 2) ? n[0] : !n[0], rx_bit_q)
      end
    end
    wr(`ULM_OFF_MODE, 32'h3);
    for (i = 16; i < 20; i++) begin
      wr(`ULM_OFF_CMD, 32'h1 << i);
      w(3);
      `CHK("cmd_pin", i[0], (i < 18) ? dtr_q : rts_q)
    end
    for (i = 0; i < 4; i++) begin
      u_peer.set_m(4'hf << (i + 1));
      w(4);
      rc(`ULM_OFF_CSR, 32'hff0000, {8'h0, 4'(4'hf << (i + 1)), 4'(1 << i), 16'h0}, "chg");
      rc(`ULM_OFF_CSR, 32'hff0000, {8'h0, 4'(4'hf << (i + 1)), 20'h0}, "chg_clr");
    end
    tx_busy <= 1'h1;
    u_peer.set_m(4'h8);
    w(3);
    `CHK("allow_busy", 1'h1, tx_allow_q)
    tx_busy <= 1'h0;
    w(3);
    `CHK("allow_off", 1'h0, tx_allow_q)
    wr(`ULM_OFF_TG, 32'h2);
    wr(`ULM_OFF_MODE, 32'h1);
    tx_idle <= 1'h0;
    w(4);
    `CHK("rts_tx", 1'h1, rts_q)
    tx_idle <= 1'h1;
    w(100);
    `CHK("rts_tg", 1'h1, rts_q)
    rc(`ULM_OFF_CSR, 32'h200, 32'h0, "tx_empty_tg");
    w(60);
    `CHK("rts_end", 1'h0, rts_q)
    rc(`ULM_OFF_CSR, 32'h200, 32'h200, "tx_empty_end");
    // Odd parity field must be overridden by the card mode
    wr(`ULM_OFF_MODE, 32'h206);
    tx_char <= 8'h07;
    rx_char <= 8'h07;
    rx_done <= 1'h1;
    w(1);
    rx_done <= 1'h0;
    w(2);
    `CHK("tx_par", 1'h1, tx_par_q)
    rc(`ULM_OFF_CSR, 32'h80, 32'h80, "par_err");
    wr(`ULM_OFF_CMD, 32'h100);
    rc(`ULM_OFF_CSR, 32'h80, 32'h0, "par_err_clr");
    wr(`ULM_OFF_RATIO, 32'h174);
    wr(`ULM_OFF_MODE, 32'h8);
    wr(`ULM_OFF_IRF, 32'ha);
    rc(`ULM_OFF_IRF, 32'hff, 32'ha, "irf");
    for (n = 0; n < 2; n++) begin
      tx_bit <= n[0];
      tx_bit_start <= 1'h1;
      w(1);
      tx_bit_start <= 1'h0;
      lows(4, 1'h0, c1);
      lows(60, 1'h0, c2);
      `CHK("ir_tx", n ? 2'h0 : 2'h3, {c1 > 0, c1 + c2 >= 8 && c1 + c2 <= 16})
    end
    for (n = 0; n < 2; n++) begin
      fork
        u_peer.pulse(n ? 20 : 6);
        lows(120, 1'h1, c2);
      join
      `CHK("ir_rx", n[0], c2 >= 60 && c2 <= 68)
    end
    wrap_up;
  end
endmodule
`default_nettype wire
